// ==== rtl/subtract_xor_swap_alu_ops.sv ====
// Accumulator ALU for subtract, exclusive-or and nibble swap operations
`timescale 1ns/1ps
`default_nettype none
module subtract_xor_swap_alu_ops (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic      [6:0]  file_addr_o,
    input  wire logic [7:0]  file_rdata_i,
    output logic      [7:0]  file_wdata_o,
    output logic             file_we_o,
    output logic             busy_o
);
    import alu_ops_pkg::*;

    alu_state_t r;
    alu_state_t next_r;
    alu_ops_if  core ();

    logic        access;
    logic        wr;
    logic [31:0] cmd_image;
    logic [31:0] status_image;
    logic [31:0] cmd_merged;
    logic        literal_op;
    logic        rd;
    logic        run;
    logic        launch;
    logic        op_active;
    logic        writes_file;
    logic [7:0]  operand;
    logic [31:0] read_word;

    logic        hit_cmd;
    logic        hit_acc;
    logic        hit_status;
    logic        hit_result;
    logic        wr_cmd;
    logic        wr_acc;
    logic        wr_status;

    logic [7:0]  new_lit;
    logic [6:0]  new_faddr;
    logic        new_dest;
    op_t         new_op;

    alu_ops_calc u_calc (
        .bus (core.calc)
    );

    // Registered ack: no new access is taken while it stands
    assign access = cyc_i && stb_i && !r.ack;
    assign wr = access && we_i;
    assign rd = access && !we_i;

    // Full decode of the four word offsets
    assign hit_cmd = (adr_i == CMD_OFS);
    assign hit_acc = (adr_i == ACC_OFS);
    assign hit_status = (adr_i == STATUS_OFS);
    assign hit_result = (adr_i == RESULT_OFS);

    // Register writes are ignored while an operation runs
    assign run = (r.seq == SEQ_RUN);
    assign wr_cmd = wr && hit_cmd && !run;
    assign wr_acc = wr && hit_acc && sel_i[0] && !run;
    assign wr_status = wr && hit_status && sel_i[0] && !run;
    assign launch = wr_cmd && sel_i[2];

    assign cmd_image = {13'h0000,
                        r.op,
                        r.dest,
                        r.faddr,
                        r.lit};
    assign status_image = {28'h0000000,
                           run,
                           r.zero,
                           r.digit_carry_flag,
                           r.carry};

    // Byte-lane merge of a command write over the held command image
    always_comb begin
        cmd_merged = cmd_image;
        for (int i = 0; i < 4; i++) begin
            if (sel_i[i]) begin
                cmd_merged[i*8 +: 8] = dat_i[i*8 +: 8];
            end
        end
    end

    assign literal_op = (r.op == OP_SUB_ACC_FROM_LITERAL)
                     || (r.op == OP_XOR_LITERAL_INTO_ACC);

    // Fields of the merged command word
    assign new_lit = cmd_merged[CMD_LIT_LSB +: 8];
    assign new_faddr = cmd_merged[CMD_FADDR_LSB +: 7];
    assign new_dest = cmd_merged[CMD_DEST_BIT];
    assign new_op = op_t'(cmd_merged[CMD_OP_LSB +: 3]);

    // Operand is the immediate or the addressed file register
    always_comb begin
        if (literal_op) begin
            operand = r.lit;
        end else begin
            operand = file_rdata_i;
        end
    end

    assign core.op = r.op;
    assign core.acc = r.acc;
    assign core.operand = operand;

    // Read data of the addressed register; unmapped offsets read zero
    always_comb begin
        if (hit_cmd) begin
            read_word = cmd_image;
        end else if (hit_acc) begin
            read_word = {24'h000000, r.acc};
        end else if (hit_status) begin
            read_word = status_image;
        end else if (hit_result) begin
            read_word = {24'h000000, r.result};
        end else begin
            read_word = 32'h00000000;
        end
    end

    // Literal forms never reach the file register, whatever the dest bit
    assign op_active = (core.op != OP_NONE);
    assign writes_file = core.to_file && (r.dest == DEST_FILE);

    always_comb begin
        next_r = r;
        next_r.ack = access;
        next_r.fwe = 1'b0;

        if (rd) begin
            next_r.rdata = read_word;
        end

        // Run lasts one cycle: result and the file write pulse land at the same edge
        unique case (r.seq)
            SEQ_IDLE: begin
                if (wr_acc) begin
                    next_r.acc = dat_i[7:0];
                end
                if (wr_status) begin
                    next_r.carry = dat_i[ST_CARRY_BIT];
                    next_r.digit_carry_flag = dat_i[ST_DIGIT_CARRY_BIT];
                    next_r.zero = dat_i[ST_ZERO_BIT];
                end
                if (wr_cmd) begin
                    next_r.lit = new_lit;
                    next_r.faddr = new_faddr;
                    next_r.dest = new_dest;
                    next_r.op = new_op;
                end
                // Launch only when the byte with the opcode is written
                if (launch) begin
                    next_r.seq = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                next_r.seq = SEQ_IDLE;
                next_r.result = core.result;
                if (writes_file) begin
                    next_r.fwdata = core.result;
                    next_r.fwe = 1'b1;
                end else if (op_active) begin
                    next_r.acc = core.result;
                end
                // Swap and the empty forms leave the flags alone
                if (core.upd_carry) begin
                    next_r.carry = core.carry;
                    next_r.digit_carry_flag = core.digit_carry_flag;
                end
                if (core.upd_zero) begin
                    next_r.zero = core.zero;
                end
            end
        endcase
    end

    // Reset loads constants; otherwise the whole copy is registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r.seq <= SEQ_IDLE;
            r.ack <= 1'b0;
            r.rdata <= 32'h00000000;
            r.acc <= ACC_RESET;
            r.carry <= 1'b0;
            r.digit_carry_flag <= 1'b0;
            r.zero <= 1'b0;
            r.op <= OP_NONE;
            r.dest <= DEST_ACC;
            r.faddr <= FADDR_RESET;
            r.lit <= LIT_RESET;
            r.result <= RESULT_RESET;
            r.fwdata <= 8'h00;
            r.fwe <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign ack_o = r.ack;
    assign dat_o = r.rdata;
    assign file_addr_o = r.faddr;
    assign file_wdata_o = r.fwdata;
    assign file_we_o = r.fwe;
    assign busy_o = run || r.fwe;

endmodule // subtract_xor_swap_alu_ops
`default_nettype wire

// ==== rtl/alu_ops_pkg.sv ====
// Constants, encodings and state types of the accumulator ALU block
package alu_ops_pkg;

    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int WB_ADR_W = 8;

    // Register byte offsets on the register bus
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] ACC_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] RESULT_OFS = 8'h0c;

    // Command register field positions
    localparam int CMD_LIT_LSB = 0;
    localparam int CMD_FADDR_LSB = 8;
    localparam int CMD_DEST_BIT = 15;
    localparam int CMD_OP_LSB = 16;

    // Status register bit positions
    localparam int ST_CARRY_BIT = 0;
    localparam int ST_DIGIT_CARRY_BIT = 1;
    localparam int ST_ZERO_BIT = 2;
    localparam int ST_BUSY_BIT = 3;

    // Values after reset
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [6:0] FADDR_RESET = 7'h00;
    localparam logic [7:0] LIT_RESET = 8'h00;

    // Destination select
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [2:0] {
        OP_NONE                 = 3'b000,
        OP_SUB_ACC_FROM_LITERAL = 3'b001,
        OP_XOR_LITERAL_INTO_ACC = 3'b010,
        OP_SUB_ACC_FROM_REGISTER = 3'b011,
        OP_XOR_ACC_WITH_REGISTER = 3'b100,
        OP_SWAP_REGISTER_NIBBLES = 3'b101
    } op_t;

    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_RUN  = 1'b1
    } seq_t;

    typedef struct packed {
        seq_t        seq;
        logic        ack;
        logic [31:0] rdata;
        logic [7:0]  acc;
        logic        carry;
        logic        digit_carry_flag;
        logic        zero;
        op_t         op;
        logic        dest;
        logic [6:0]  faddr;
        logic [7:0]  lit;
        logic [7:0]  result;
        logic [7:0]  fwdata;
        logic        fwe;
    } alu_state_t;

endpackage

// ==== rtl/alu_ops_if.sv ====
// Carrier between the sequencer and the combinational ALU core
`timescale 1ns/1ps
`default_nettype none
interface alu_ops_if;
    import alu_ops_pkg::*;
    op_t        op;
    logic [7:0] operand;
    logic [7:0] acc;
    logic [7:0] result;
    logic       carry;
    logic       digit_carry_flag;
    logic       zero;
    logic       upd_carry;
    logic       upd_zero;
    logic       to_file;

    modport seq  (output op, operand, acc,
                  input  result, carry, digit_carry_flag, zero,
                         upd_carry, upd_zero, to_file);
    modport calc (input  op, operand, acc,
                  output result, carry, digit_carry_flag, zero,
                         upd_carry, upd_zero, to_file);
endinterface
`default_nettype wire

// ==== rtl/alu_ops_calc.sv ====
// Combinational result and flag logic for the five accumulator operations
`timescale 1ns/1ps
`default_nettype none
module alu_ops_calc (
    alu_ops_if.calc bus
);
    import alu_ops_pkg::*;

    logic [8:0] diff;
    logic [4:0] low_diff;

    // Operand minus accumulator, two's complement: add inverse plus one
    assign diff = {1'b0, bus.operand} + {1'b0, ~bus.acc} + 9'h001;
    assign low_diff = {1'b0, bus.operand[3:0]} + {1'b0, ~bus.acc[3:0]}
                    + 5'h01;

    always_comb begin
        bus.result = bus.operand;
        bus.upd_carry = 1'b0;
        bus.upd_zero = 1'b0;
        bus.to_file = 1'b0;
        unique case (bus.op)
            OP_SUB_ACC_FROM_LITERAL: begin
                bus.result = diff[7:0];
                bus.upd_carry = 1'b1;
                bus.upd_zero = 1'b1;
            end
            OP_XOR_LITERAL_INTO_ACC: begin
                bus.result = bus.acc ^ bus.operand;
                bus.upd_zero = 1'b1;
            end
            OP_SUB_ACC_FROM_REGISTER: begin
                bus.result = diff[7:0];
                bus.upd_carry = 1'b1;
                bus.upd_zero = 1'b1;
                bus.to_file = 1'b1;
            end
            OP_XOR_ACC_WITH_REGISTER: begin
                bus.result = bus.acc ^ bus.operand;
                bus.upd_zero = 1'b1;
                bus.to_file = 1'b1;
            end
            OP_SWAP_REGISTER_NIBBLES: begin
                bus.result = {bus.operand[3:0], bus.operand[7:4]};
                bus.to_file = 1'b1;
            end
            OP_NONE: begin
                bus.result = bus.acc;
            end
            default: begin
                bus.result = bus.acc;
            end
        endcase
    end

    // Carry means no borrow out of bit 7, digit carry none out of bit 3
    assign bus.carry = diff[8];
    assign bus.digit_carry_flag = low_diff[4];
    assign bus.zero = (bus.result == 8'h00);

endmodule // alu_ops_calc
`default_nettype wire

// ==== test/alu_ops_props.sv ====
// Concurrent checks of the accumulator ALU block
`timescale 1ns/1ps
`default_nettype none
module alu_ops_props
    import alu_ops_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic [6:0]  file_addr_o,
    input wire logic [7:0]  file_rdata_i,
    input wire logic [7:0]  file_wdata_o,
    input wire logic        file_we_o,
    input wire logic        busy_o
);
    logic [7:0] fr_q;
    logic [7:0] acc;
    logic [6:0] fa_q;
    logic       ok;
    wire        w = cyc_i & stb_i & we_i & ~ack_o;
    wire        wa = w & sel_i[0] & adr_i == ACC_OFS;
    wire        go = w & sel_i[2] & adr_i == CMD_OFS;
    wire  [2:0] opc = dat_i[18:16];
    wire        dst = dat_i[15];
    // Shadow accumulator, trusted only until an op may change it
    always_ff @(posedge clk_i) begin
        fr_q <= file_rdata_i;
        fa_q <= dat_i[14:8];
        acc <= rst_i ? ACC_RESET : (wa ? dat_i[7:0] : acc);
        ok <= rst_i | wa | (ok & ~(go & (~dst | opc < 3'h3)));
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_swap_data: assert property (go && opc == 3'h5 && dst
        |-> ##2 file_we_o && file_wdata_o == {fr_q[3:0], fr_q[7:4]})
        else $error("bad swap data");
    a_sub_file: assert property (go && opc == 3'h3 && dst && ok
        |-> ##2 file_we_o && file_wdata_o == 8'(fr_q - acc))
        else $error("bad subtract data");
    a_xor_file: assert property (go && opc == 3'h4 && dst && ok
        |-> ##2 file_we_o && file_wdata_o == (fr_q ^ acc))
        else $error("bad xor data");
    a_acc_dest: assert property (go && !dst
        |=> !file_we_o [*2]) else $error("file written for acc dest");
    a_lit_dest: assert property (go && opc inside {3'h1, 3'h2}
        |=> !file_we_o [*2]) else $error("literal op wrote file");
    a_file_addr: assert property (go
        |=> file_addr_o == fa_q && busy_o) else $error("bad file address");
    a_we_pulse: assert property (file_we_o
        |=> !file_we_o) else $error("file write too long");
    c_swap: cover property (go && opc == 3'h5 && dst);
    c_sub: cover property (go && opc == 3'h3 && dst);
    c_lit: cover property (go && opc == 3'h1);
endmodule // alu_ops_props
bind subtract_xor_swap_alu_ops alu_ops_props u_props (.clk_i, .rst_i,
    .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .file_addr_o, .file_rdata_i, .file_wdata_o, .file_we_o, .busy_o);
`default_nettype wire

// ==== test/file_reg_model.sv ====
// File register model standing behind the ALU block
`timescale 1ns/1ps
`default_nettype none
module file_reg_model (
    input  wire logic       clk_i,
    input  wire logic [6:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       we_i,
    output logic      [7:0] rdata_o
);
    logic [7:0] mem [128];
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    assign rdata_o = mem[addr_i];
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end
endmodule // file_reg_model
`default_nettype wire

// ==== test/subtract_xor_swap_alu_ops_tb_top.sv ====
// Self-checking bench of the accumulator ALU block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %0t %h %h", $time, g, e); end end
module subtract_xor_swap_alu_ops_tb_top;
    import alu_ops_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
    logic        we = 1'b0, ack, fwe;
    logic [7:0]  adr = 8'h00, fwd, frd;
    logic [3:0]  sel = 4'hf;
    logic [6:0]  fad;
    logic [31:0] wd = 32'h0, rdat, q;
    int          n_fail = 0, checked = 0, ticks = 0;
    subtract_xor_swap_alu_ops uut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wd), .dat_o(rdat), .ack_o(ack), .file_addr_o(fad),
        .file_rdata_i(frd), .file_wdata_o(fwd), .file_we_o(fwe),
        .busy_o());
    file_reg_model fm (.clk_i(clk_i), .addr_i(fad), .wdata_i(fwd),
        .we_i(fwe), .rdata_o(frd));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task automatic end_sim();
        if (n_fail == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        ticks <= ticks + 1;
        if (ticks == 500) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(STATUS_OFS, 32'h0);
        wb(1'b1, ACC_OFS, 32'h15);
        wb(1'b1, CMD_OFS, 32'h18006);
        rd(ACC_OFS, 32'hf1);
        rd(STATUS_OFS, 32'h2);
        wb(1'b1, CMD_OFS, 32'h200f1);
        rd(ACC_OFS, 32'h0);
        rd(STATUS_OFS, 32'h6);
        wb(1'b1, ACC_OFS, 32'h10);
        wb(1'b1, CMD_OFS, 32'h3ff00);
        rd(ACC_OFS, 32'h10);
        rd(STATUS_OFS, 32'h3);
        `CHK(fm.mem[127], 8'h15)
        wb(1'b1, CMD_OFS, 32'h48200);
        rd(STATUS_OFS, 32'h3);
        `CHK(fm.mem[2], 8'h48)
        wb(1'b1, CMD_OFS, 32'h44a00);
        rd(ACC_OFS, 32'h0);
        rd(STATUS_OFS, 32'h7);
        wb(1'b1, CMD_OFS, 32'h58100);
        wb(1'b1, CMD_OFS, 32'h50300);
        `CHK(fm.mem[1], 8'hb5)
        rd(ACC_OFS, 32'h95);
        rd(STATUS_OFS, 32'h7);
        wb(1'b1, CMD_OFS, 32'h7ffff);
        rd(ACC_OFS, 32'h95);
        `CHK(fm.mem[127], 8'h15)
        wb(1'b1, RESULT_OFS, 32'haa);
        rd(RESULT_OFS, 32'h95);
        rd(8'h10, 32'h0);
        end_sim();
    end
endmodule // subtract_xor_swap_alu_ops_tb_top
`default_nettype wire
